// file: ocs_clk_sel.sv
// Purpose: Selects the master switching cycle start from sync or internal oscillator.
// Assumes: Sync and oscillator ticks are synchronous levels on ref_clk.
// Notes: Falling edge of sync marks a cycle start while sync is active.
`timescale 1ns/1ps
module ocs_clk_sel (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic clkEn,
   input  wire logic syncIn,
   input  wire logic oscTick,
   output logic      cycleStart,
   output logic      syncActive
);
   logic                        syncPrev_reg;
   logic [ocs_pkg::SYNC_TO_W-1:0] syncTimer_reg;
   logic                        syncFall;

   assign syncFall = syncPrev_reg & ~syncIn;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         syncPrev_reg <= 1'b0;
      end else if (clkEn) begin
         syncPrev_reg <= syncIn;
      end
   end

   // Sync held low stops refreshing the timer, so the oscillator takes over.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         syncTimer_reg <= ocs_pkg::SYNC_TO_ZERO;
      end else if (clkEn) begin
         if (syncFall) begin
            syncTimer_reg <= ocs_pkg::SYNC_TO_MAX; // RL11
         end else if (syncTimer_reg != ocs_pkg::SYNC_TO_ZERO) begin
            syncTimer_reg <= syncTimer_reg - ocs_pkg::SYNC_TO_ONE; // RL12
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cycleStart <= 1'b0;
         syncActive <= 1'b0;
      end else if (clkEn) begin
         syncActive <= syncFall | (syncTimer_reg != ocs_pkg::SYNC_TO_ZERO);
         if (syncFall | (syncTimer_reg != ocs_pkg::SYNC_TO_ZERO)) begin
            cycleStart <= syncFall; // RL10 RL11
         end else begin
            cycleStart <= oscTick; // RL12
         end
      end
   end
endmodule : ocs_clk_sel

// file: ocs_ctrl.sv
// Purpose: Pulse-by-pulse current limit, hiccup fault counter and undervoltage cut.
// Assumes: Sense inputs are synchronous; soft-start analog loop is outside.
// Notes: Gate drive outputs are active high meaning switch on.
`timescale 1ns/1ps
module ocs_ctrl (
   input  wire logic               ref_clk,
   input  wire logic               rst,
   input  wire logic               clkEn,
   input  wire logic               syncIn,
   input  wire logic               oscTick,
   input  wire ocs_pkg::ocs_sense_t sense,
   output ocs_pkg::ocs_drive_t      drive,
   output logic                     restartActive,
   output logic                     undervoltage_lockout,
   output logic [ocs_pkg::CNT_W-1:0] faultCount,
   output logic                     syncActive
);
   logic                   cycleStart;
   logic                   syncActiveInt;
   ocs_pkg::ocs_state_t    state_reg;
   ocs_pkg::ocs_state_t    state_next;
   logic [ocs_pkg::CNT_W-1:0] count_reg;
   logic [ocs_pkg::CNT_W-1:0] count_next;
   logic                   highOn_reg;
   logic                   cutHold_reg;
   logic                   ocCycle_reg;
   logic                   rampDone_reg;
   logic                   ocEvent;
   logic                   pwmAllowed;

   ocs_clk_sel u_clk_sel (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .clkEn      (clkEn),
      .syncIn     (syncIn),
      .oscTick    (oscTick),
      .cycleStart (cycleStart),
      .syncActive (syncActiveInt)
   );

   assign pwmAllowed = (state_reg == ocs_pkg::OCS_RUN);
   assign ocEvent    = highOn_reg & sense.overCurrent;

   // High-side pulse: starts at cycle start, ends on PWM end or overcurrent.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         highOn_reg <= 1'b0;
      end else if (clkEn) begin
         if (!pwmAllowed) begin
            highOn_reg <= 1'b0; // RL6 RL13
         end else if (ocEvent) begin
            highOn_reg <= 1'b0; // RL1
         end else if (cycleStart) begin
            highOn_reg <= 1'b1; // RL10
         end else if (sense.pwmEnd || cutHold_reg) begin
            highOn_reg <= 1'b0; // RL2
         end
      end
   end

   // Holds the high side off after a cut until the next cycle begins.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cutHold_reg <= 1'b0;
      end else if (clkEn) begin
         if (ocEvent) begin
            cutHold_reg <= 1'b1; // RL2
         end else if (cycleStart) begin
            cutHold_reg <= 1'b0;
         end
      end
   end

   // Marks that the current switching cycle already counted an overcurrent.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ocCycle_reg <= 1'b0;
      end else if (clkEn) begin
         // An overcurrent at the cycle boundary still marks the new cycle.
         if (ocEvent) begin
            ocCycle_reg <= 1'b1;
         end else if (cycleStart) begin
            ocCycle_reg <= 1'b0;
         end
      end
   end

   // Ramp progress within the cycle, used for the undervoltage check.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rampDone_reg <= 1'b0;
      end else if (clkEn) begin
         if (cycleStart) begin
            rampDone_reg <= 1'b0;
         end else if (sense.rampAtNinety) begin
            rampDone_reg <= 1'b1;
         end
      end
   end

   // Fault counter, saturating at both ends.
   always_comb begin
      count_next = count_reg;
      if (state_reg == ocs_pkg::OCS_RESTART) begin
         if (sense.softStartDone && count_reg != ocs_pkg::CNT_ZERO) begin
            count_next = count_reg - ocs_pkg::CNT_ONE; // RL7 RL16
         end
      end else if (ocEvent && !ocCycle_reg) begin
         if (count_reg != ocs_pkg::CNT_LIMIT) begin
            count_next = count_reg + ocs_pkg::CNT_ONE; // RL3 RL9 RL16
         end
      end else if (!ocEvent && !ocCycle_reg && cycleStart) begin
         if (count_reg != ocs_pkg::CNT_ZERO) begin
            count_next = count_reg - ocs_pkg::CNT_ONE; // RL4 RL16
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         count_reg <= ocs_pkg::CNT_ZERO;
      end else if (clkEn) begin
         count_reg <= count_next;
      end
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ocs_pkg::OCS_RUN: begin
            // Any cycle start, sync or oscillator, that cuts the ramp short locks out.
            if (cycleStart && !rampDone_reg) begin
               state_next = ocs_pkg::OCS_LOCKOUT; // RL13 RL15
            end else if (count_next == ocs_pkg::CNT_LIMIT) begin
               state_next = ocs_pkg::OCS_RESTART; // RL5 RL9
            end
         end
         ocs_pkg::OCS_RESTART: begin
            if (count_next == ocs_pkg::CNT_ZERO) begin
               state_next = ocs_pkg::OCS_RUN; // RL8
            end
         end
         ocs_pkg::OCS_LOCKOUT: begin
            state_next = ocs_pkg::OCS_LOCKOUT;
         end
         default: begin
            state_next = ocs_pkg::OCS_RUN;
         end
      endcase
   end

   // Undervoltage lockout is left only by reset; OCS_LOCKOUT has no other exit.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_reg <= ocs_pkg::OCS_RUN;
      end else if (clkEn) begin
         state_reg <= state_next;
      end
   end

   // Registered outputs; low side is the complement of highOn_reg while running, so an overcurrent clock turns both off.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         drive                <= '0;
         restartActive        <= 1'b0;
         undervoltage_lockout <= 1'b0;
         faultCount           <= ocs_pkg::CNT_ZERO;
         syncActive           <= 1'b0;
      end else if (clkEn) begin
         drive.high_side_gate_drive <= highOn_reg & pwmAllowed & ~ocEvent; // RL1 RL6
         drive.low_side_gate_drive  <= ~highOn_reg & pwmAllowed; // RL6
         restartActive        <= (state_reg == ocs_pkg::OCS_RESTART);
         undervoltage_lockout <= (state_reg == ocs_pkg::OCS_LOCKOUT);
         faultCount           <= count_reg;
         syncActive           <= syncActiveInt;
      end
   end
endmodule : ocs_ctrl

// file: ocs_ctrl_chk.sv
// Purpose: Port checker for the overcurrent hiccup and sync control block.
// Assumes: One clock domain, asynchronous active high reset.
// Notes: Start history covers two to five clocks back from a high-side rise.
`timescale 1ns/1ps
module ocs_ctrl_chk (
   input wire logic                      ref_clk,
   input wire logic                      rst,
   input wire logic                      clkEn,
   input wire logic                      syncIn,
   input wire logic                      oscTick,
   input wire ocs_pkg::ocs_sense_t       sense,
   input wire ocs_pkg::ocs_drive_t       drive,
   input wire logic                      restartActive,
   input wire logic                      undervoltage_lockout,
   input wire logic [ocs_pkg::CNT_W-1:0] faultCount,
   input wire logic                      syncActive
);
   logic       syncPrev_reg;
   logic [4:0] srcHist_reg;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         syncPrev_reg <= 1'b0;
         srcHist_reg  <= 5'h00;
      end else begin
         syncPrev_reg <= syncIn;
         srcHist_reg  <= {srcHist_reg[3:0], oscTick | (syncPrev_reg & ~syncIn)};
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   restart_off_a: assert property (restartActive |-> drive == 2'h0)
      else $error("drives on during restart");
   uv_off_a: assert property (undervoltage_lockout |-> drive == 2'h0)
      else $error("drives on during undervoltage");
   uv_sticky_a: assert property (undervoltage_lockout |=> undervoltage_lockout)
      else $error("undervoltage released");
   oc_cut_a: assert property (clkEn && sense.overCurrent && drive.high_side_gate_drive
      |=> !drive.high_side_gate_drive) else $error("high side not cut");
   hi_start_a: assert property ($rose(drive.high_side_gate_drive) |-> |srcHist_reg[4:1])
      else $error("high side rose without cycle start");
   cnt_step_a: assert property ($changed(faultCount) |->
      faultCount == $past(faultCount) + 3'h1 || faultCount == $past(faultCount) - 3'h1)
      else $error("fault count jumped");
   cnt_wrap_a: assert property (!($past(faultCount) == 3'h7 && faultCount == 3'h0) &&
      !($past(faultCount) == 3'h0 && faultCount == 3'h7)) else $error("fault count wrapped");
   restart_entry_a: assert property (faultCount == 3'h7 && !undervoltage_lockout
      |-> ##[0:2] restartActive) else $error("no restart at seven");
   restart_exit_a: assert property ($fell(restartActive) |-> ##[0:1] faultCount == 3'h0)
      else $error("restart left with count not zero");
   cover property (restartActive ##1 !restartActive);
   cover property ($rose(undervoltage_lockout));
   cover property ($rose(syncActive));
endmodule : ocs_ctrl_chk
bind ocs_ctrl ocs_ctrl_chk ocs_ctrl_chk_i (.ref_clk, .rst, .clkEn, .syncIn, .oscTick, .sense,
   .drive, .restartActive, .undervoltage_lockout, .faultCount, .syncActive);

// file: ocs_pkg.sv
// Purpose: Shared constants and types for the overcurrent hiccup and sync control block.
// Assumes: All inputs except the asynchronous reset are synchronous to ref_clk at 250 MHz.
// Notes: Analog comparators are outside; their outcomes arrive as logic levels.
// Functional notes
// RL1: Overcurrent during the high-side on-time ends the high-side pulse immediately.
// RL2: After an overcurrent cut, high side stays off until next cycle starts.
// RL3: Fault counter increments once per cycle containing an overcurrent-terminated pulse.
// RL4: Fault counter decrements once per clock cycle without an overcurrent event.
// RL5: Counter reaching seven issues restart and begins seven soft-start cycles.
// RL6: Both gate drives are held off throughout the restart sequence.
// RL7: During restart the counter decrements at each soft-start cycle completion.
// RL8: Counter back at zero during restart re-enables PWM switching.
// RL9: Persistent overcurrent after resuming counts seven again and restarts again.
// RL10: Synchronized operation starts each high-side on-time at the sync falling edge.
// RL11: A toggling external clock replaces the internal oscillator as master clock.
// RL12: External clock held low lets the internal oscillator free-run.
// RL13: Sync edge before ramp completes declares undervoltage and disables PWM.
// RL14: External clock should be 20% to 30% faster than free-run frequency.
// RL15: Undervoltage when the clock edge arrives before the ramp reaches 90% amplitude.
// RL16: Fault counter saturates at zero and seven, never wrapping.
package ocs_pkg;
   localparam int         CNT_W        = 3;
   localparam logic [2:0] CNT_ZERO     = 3'h0;
   localparam logic [2:0] CNT_ONE      = 3'h1;
   localparam logic [2:0] CNT_LIMIT    = 3'h7;
   // Sync counts as toggling while a falling edge was seen within this many clocks.
   localparam int         SYNC_TO_W    = 12;
   localparam logic [11:0] SYNC_TO_MAX = 12'h0FA0;
   localparam logic [11:0] SYNC_TO_ZERO = 12'h0000;
   localparam logic [11:0] SYNC_TO_ONE = 12'h0001;

   typedef enum logic [1:0] {
      OCS_RUN     = 2'b00,
      OCS_RESTART = 2'b01,
      OCS_LOCKOUT = 2'b10
   } ocs_state_t;

   // Analog side indications, one bundle.
   typedef struct packed {
      logic overCurrent;   // Drop across high-side switch exceeds limit.
      logic pwmEnd;        // PWM comparator ends the on-time.
      logic rampAtNinety;  // Ramp has reached 90% of full amplitude.
      logic softStartDone; // One soft-start cycle has completed.
   } ocs_sense_t;

   typedef struct packed {
      logic high_side_gate_drive;
      logic low_side_gate_drive;
   } ocs_drive_t;
endpackage : ocs_pkg

// file: ocs_sync_src.sv
// Purpose: External clock source that drives the sync input of the control block.
// Assumes: Half period is counted in ref_clk cycles.
// Notes: While stopped the line rests low, as the pin's pull-down would leave it.
`timescale 1ns/1ps
module ocs_sync_src #(parameter int HALF = 10) (
   input  wire logic ref_clk,
   input  wire logic run,
   output logic      syncIn
);
   int cnt = 0;
   initial syncIn = 1'b0;
   // Period of 20 clocks runs 25% faster than the bench's 25 clock oscillator.
   always @(posedge ref_clk) begin
      cnt <= (!run || cnt == 2 * HALF - 1) ? 0 : cnt + 1;
      syncIn <= #1 run && (cnt >= HALF);
   end
endmodule : ocs_sync_src

// file: test_overcurrent_hiccup_and_sync_ctrl.sv
// Purpose: Self-checking bench for the overcurrent hiccup and sync control block.
// Assumes: Oscillator ticks every 25 clocks; sync source period is 20 clocks.
// Notes: Events are 1 high on, 2 restart in, 3 restart out, 4 sync on, 5 sync off, 6 lockout.
`timescale 1ns/1ps
module test_overcurrent_hiccup_and_sync_ctrl;
   logic                      ref_clk = 1'b0;
   logic                      rst = 1'b1;
   logic                      clkEn = 1'b1;
   logic                      oscTick = 1'b0;
   logic                      syncRun = 1'b0;
   logic                      skipHi = 1'b0;
   logic                      syncIn, restartActive, undervoltage_lockout, syncActive;
   logic                      pHi = 1'b0, pRs = 1'b0, pSa = 1'b0, pUv = 1'b0;
   logic [ocs_pkg::CNT_W-1:0] faultCount;
   logic [2:0]                expQ[$];
   ocs_pkg::ocs_sense_t       sense = '0;
   ocs_pkg::ocs_drive_t       drive;
   int                        miscompares = 0;
   int                        num_checks = 0;
   integer                    seed = 67403;
   always #2 ref_clk = ~ref_clk;
   ocs_ctrl ocs_ctrl_i (.ref_clk, .rst, .clkEn, .syncIn, .oscTick, .sense, .drive,
      .restartActive, .undervoltage_lockout, .faultCount, .syncActive);
   ocs_sync_src ocs_sync_src_i (.ref_clk, .run(syncRun), .syncIn);
   task automatic finish_test();
      if (expQ.size() != 0) begin
         miscompares++;
         $display("[ERR] events expected %0d more seen 0", expQ.size());
      end
      if (miscompares == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test
   task automatic note(input logic [2:0] e);
      logic [2:0] x;
      x = (expQ.size() == 0) ? 3'h0 : expQ.pop_front();
      num_checks++;
      if (x !== e) begin
         miscompares++;
         $display("[ERR] event expected %0d seen %0d", x, e);
      end
   endtask : note
   always @(negedge ref_clk) begin
      if (!rst) begin
         if (drive.high_side_gate_drive === 1'b1 && !pHi && !skipHi) note(3'h1);
         if (restartActive === 1'b1 && !pRs) note(3'h2);
         if (restartActive === 1'b0 && pRs) note(3'h3);
         if (syncActive === 1'b1 && !pSa) note(3'h4);
         if (syncActive === 1'b0 && pSa) note(3'h5);
         if (undervoltage_lockout === 1'b1 && !pUv) note(3'h6);
      end
      pHi = drive.high_side_gate_drive;
      pRs = restartActive;
      pSa = syncActive;
      pUv = undervoltage_lockout;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic cyc(input logic oc, input logic last);
      int d;
      d = 4 + ({$random(seed)} % 3);
      expQ.push_back(3'h1);
      if (last) expQ.push_back(3'h2);
      oscTick = 1'b1;
      tick(1);
      oscTick = 1'b0;
      tick(d);
      sense.overCurrent = oc;
      sense.pwmEnd = !oc;
      tick(1);
      sense.overCurrent = 1'b0;
      sense.pwmEnd = 1'b0;
      tick(23 - d);
   endtask : cyc
   task automatic hiccup();
      for (int i = 0; i < 7; i++) cyc(1'b1, i == 6);
      // Soft-start pulses while the clock enable is low must not move the counter.
      clkEn = 1'b0;
      repeat (7) begin
         sense.softStartDone = 1'b1;
         tick(1);
         sense.softStartDone = 1'b0;
         tick(1);
      end
      clkEn = 1'b1;
      for (int i = 0; i < 7; i++) begin
         if (i == 6) expQ.push_back(3'h3);
         sense.softStartDone = 1'b1;
         tick(1);
         sense.softStartDone = 1'b0;
         tick(4);
      end
   endtask : hiccup
   initial begin
      tick(4);
      rst = 1'b0;
      sense.rampAtNinety = 1'b1;
      tick(2);
      cyc(1'b0, 1'b0);
      hiccup();
      cyc(1'b0, 1'b0);
      hiccup();
      for (int k = 0; k < 2; k++) begin
         skipHi = 1'b1;
         expQ.push_back(3'h4);
         syncRun = 1'b1;
         tick(200);
         if (k == 1) expQ.push_back(3'h6);
         sense.rampAtNinety = k == 0;
         syncRun = k == 1;
         if (k == 0) expQ.push_back(3'h5);
         tick(4200);
         sense.pwmEnd = 1'b1;
         tick(1);
         sense.pwmEnd = 1'b0;
         tick(1);
         skipHi = 1'b0;
         if (k == 0) cyc(1'b0, 1'b0);
      end
      finish_test();
   end
   initial begin
      #200000;
      miscompares++;
      finish_test();
   end
endmodule : test_overcurrent_hiccup_and_sync_ctrl
